// ===== hw/lre_evaluator.sv
// ladder rung scanner with logic reset, jumps, heater and index actions
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "lre_defines.svh"

//Contract
// - action 69 expires timers, clears variables
// - actions 70-99 jump to rungs 0-29
// - skipped rungs are not executed
// - backward or same-rung jump flags error
// - action 150 drives heater from condition
// - actions 25-28 form preset index
// - all preset bits set selects zero speed
// - actions 36,35 form table index
// - undriven preset bits read zero
// - rungs run in ascending order
module lre_evaluator (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // condition sources
  input  wire logic [15:0] i_din,
  input  wire logic [3:0]  i_comp,
  input  wire logic [3:0]  i_timer_done,
  // drive control outputs
  output logic      [3:0]  o_preset_idx,
  output logic             o_zero_speed,
  output logic      [1:0]  o_table_idx,
  output logic             o_heater_en,
  output logic             o_timer_expire,
  output logic             o_irq
);
  import lre_pkg::*;

  // ************************************************************
  // condition evaluation
  // ************************************************************
  function automatic logic lre_cond(input logic [7:0] code,
                                    input logic [15:0] din,
                                    input logic [3:0] cmp,
                                    input logic [3:0] tmr,
                                    input logic [9:0] vars);
    logic [7:0] off;
    off = 8'h0;
    lre_cond = 1'b0;
    if (code == `LRE_C_TRUE) begin
      lre_cond = 1'b1;
    end else if (code >= `LRE_C_DIN_LO && code <= `LRE_C_DIN_HI) begin
      off = code - `LRE_C_DIN_LO;
      lre_cond = din[off[3:0]];
    end else if (code >= `LRE_C_CMP_LO && code <= `LRE_C_CMP_HI) begin
      off = code - `LRE_C_CMP_LO;
      lre_cond = cmp[off[1:0]];
    end else if (code >= `LRE_C_TMR_LO && code <= `LRE_C_TMR_HI) begin
      off = code - `LRE_C_TMR_LO;
      lre_cond = tmr[off[1:0]];
    end else if (code >= `LRE_C_VAR_LO && code <= `LRE_C_VAR_HI) begin
      off = code - `LRE_C_VAR_LO;
      lre_cond = vars[off[3:0]];
    end
  endfunction : lre_cond

  lre_state_t  state_ff;
  lre_state_t  nxt_state;
  logic [4:0]  rung_ff;
  logic [4:0]  nxt_rung;
  logic [9:0]  vars_ff;
  logic [9:0]  nxt_vars;
  logic [3:0]  pacc_ff;
  logic [3:0]  nxt_pacc;
  logic [1:0]  tacc_ff;
  logic [1:0]  nxt_tacc;
  logic [3:0]  nxt_preset_idx;
  logic        nxt_zero_speed;
  logic [1:0]  nxt_table_idx;
  logic        nxt_heater_en;
  logic        nxt_timer_expire;
  logic        ev_jump_err;
  logic        ev_done;
  logic        ev_reset;
  logic [31:0] rung_word;
  logic        cond_a;
  logic        cond_b;
  logic        rung_true;
  logic [7:0]  act;
  logic [7:0]  act_off;
  logic [4:0]  jump_tgt;
  logic        ctrl_run_ff;
  logic        nxt_ctrl_run;
  logic [2:0]  status_ff;
  logic [2:0]  nxt_status;
  logic [2:0]  mask_ff;
  logic [2:0]  nxt_mask;
  logic        nxt_irq;
  logic [31:0] nxt_rdata;
  logic        mem_we;

  // ************************************************************
  // rung store
  // ************************************************************
  assign mem_we = i_wr && (i_addr <= `LRE_ADDR_RUNG_LAST);

  lre_rung_mem u_mem (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_we      (mem_we),
    .i_waddr   (i_addr[4:0]),
    .i_wdata   (i_wdata),
    .i_raddr   (rung_ff),
    .o_rdata   (rung_word)
  );

  // split the rung word into its four byte fields
  assign cond_a = lre_cond(rung_word[`LRE_F_COND_A], i_din, i_comp,
                           i_timer_done, vars_ff);
  assign cond_b = lre_cond(rung_word[`LRE_F_COND_B], i_din, i_comp,
                           i_timer_done, vars_ff);
  assign act    = rung_word[`LRE_F_ACTION];
  assign act_off = act - `LRE_A_JUMP_LO;
  assign jump_tgt = act_off[4:0];

  always_comb begin
    case (rung_word[`LRE_F_LOGIC])
      `LRE_OP_OR:  rung_true = cond_a | cond_b;
      `LRE_OP_AND: rung_true = cond_a & cond_b;
      `LRE_OP_XOR: rung_true = cond_a ^ cond_b;
      `LRE_OP_NOR: rung_true = ~(cond_a | cond_b);
      default:     rung_true = 1'b0;
    endcase
  end

  // ************************************************************
  // scan engine
  // ************************************************************
  always_comb begin
    logic [7:0] off;
    off              = 8'h0;
    nxt_state        = state_ff;
    nxt_rung         = rung_ff;
    nxt_vars         = vars_ff;
    nxt_pacc         = pacc_ff;
    nxt_tacc         = tacc_ff;
    nxt_preset_idx   = o_preset_idx;
    nxt_zero_speed   = o_zero_speed;
    nxt_table_idx    = o_table_idx;
    nxt_heater_en    = o_heater_en;
    nxt_timer_expire = 1'b0;
    ev_jump_err      = 1'b0;
    ev_done          = 1'b0;
    ev_reset         = 1'b0;
    case (state_ff)
      LRE_S_IDLE: begin
        if (ctrl_run_ff) begin
          // index bits nobody drives this scan stay zero
          nxt_pacc  = 4'h0;
          nxt_tacc  = 2'h0;
          nxt_rung  = 5'h0;
          nxt_state = LRE_S_READ;
        end
      end
      LRE_S_READ: begin
        nxt_state = LRE_S_EXEC;
      end
      LRE_S_EXEC: begin
        nxt_rung = rung_ff + 5'h1;
        if (act >= `LRE_A_VAR_LO && act <= `LRE_A_VAR_HI) begin
          off = act - `LRE_A_VAR_LO;
          nxt_vars[off[3:0]] = rung_true;
        end else if (act >= `LRE_A_PRESET_LO &&
                     act <= `LRE_A_PRESET_HI) begin
          off = act - `LRE_A_PRESET_LO;
          nxt_pacc[off[1:0]] = rung_true;
        end else if (act >= `LRE_A_TABLE_LO &&
                     act <= `LRE_A_TABLE_HI) begin
          off = act - `LRE_A_TABLE_LO;
          nxt_tacc[off[0]] = rung_true;
        end else if (act == `LRE_A_HEATER) begin
          nxt_heater_en = rung_true;
        end else if (act == `LRE_A_PLC_RESET && rung_true) begin
          // comparators live outside and are left alone
          nxt_vars         = 10'h0;
          nxt_timer_expire = 1'b1;
          ev_reset         = 1'b1;
        end else if (act >= `LRE_A_JUMP_LO && act <= `LRE_A_JUMP_HI &&
                     rung_true) begin
          if (jump_tgt > rung_ff) begin
            nxt_rung = jump_tgt;
          end else begin
            ev_jump_err = 1'b1;
          end
        end
        if (nxt_rung == `LRE_NUM_RUNGS) begin
          // preset, zero-speed and table outputs change only once per scan, never mid-scan
          nxt_preset_idx = nxt_pacc;
          nxt_zero_speed = (nxt_pacc == `LRE_PRESET_ZERO);
          nxt_table_idx  = nxt_tacc;
          nxt_rung       = 5'h0;
          ev_done        = 1'b1;
          nxt_state      = LRE_S_IDLE;
        end else begin
          nxt_state = LRE_S_READ;
        end
      end
      default: begin
        nxt_state = LRE_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff       <= LRE_S_IDLE;
      rung_ff        <= 5'h0;
      vars_ff        <= 10'h0;
      pacc_ff        <= 4'h0;
      tacc_ff        <= 2'h0;
      o_preset_idx   <= 4'h0;
      o_zero_speed   <= 1'b0;
      o_table_idx    <= 2'h0;
      o_heater_en    <= 1'b0;
      o_timer_expire <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      rung_ff        <= nxt_rung;
      vars_ff        <= nxt_vars;
      pacc_ff        <= nxt_pacc;
      tacc_ff        <= nxt_tacc;
      o_preset_idx   <= nxt_preset_idx;
      o_zero_speed   <= nxt_zero_speed;
      o_table_idx    <= nxt_table_idx;
      o_heater_en    <= nxt_heater_en;
      o_timer_expire <= nxt_timer_expire;
    end
  end

  // ************************************************************
  // registers and interrupt
  // ************************************************************
  always_comb begin
    nxt_ctrl_run = ctrl_run_ff;
    nxt_mask     = mask_ff;
    nxt_rdata    = 32'h0;
    nxt_status   = status_ff;
    if (i_wr && i_addr == `LRE_ADDR_CTRL) begin
      nxt_ctrl_run = i_wdata[`LRE_CTRL_RUN];
    end
    if (i_wr && i_addr == `LRE_ADDR_MASK) begin
      nxt_mask = i_wdata[2:0];
    end
    if (i_wr && i_addr == `LRE_ADDR_STATUS) begin
      nxt_status = status_ff & ~i_wdata[2:0];
    end
    // a new event beats a clear in the same cycle
    nxt_status = nxt_status | {ev_reset, ev_done, ev_jump_err};
    nxt_irq = |(nxt_status & nxt_mask);
    if (i_rd) begin
      case (i_addr)
        `LRE_ADDR_CTRL:   nxt_rdata = {31'h0, ctrl_run_ff};
        `LRE_ADDR_STATUS: nxt_rdata = {29'h0, status_ff};
        `LRE_ADDR_MASK:   nxt_rdata = {29'h0, mask_ff};
        `LRE_ADDR_STATE:  nxt_rdata = {9'h0, rung_ff, vars_ff, o_heater_en,
                                       o_table_idx, o_zero_speed,
                                       o_preset_idx};
        default:          nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_run_ff <= `LRE_CTRL_RST_VAL;
      mask_ff     <= 3'h0;
      status_ff   <= 3'h0;
      o_irq       <= 1'b0;
      o_rdata     <= 32'h0;
    end else begin
      ctrl_run_ff <= nxt_ctrl_run;
      mask_ff     <= nxt_mask;
      status_ff   <= nxt_status;
      o_irq       <= nxt_irq;
      o_rdata     <= nxt_rdata;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic exec_now;
  assign exec_now = (state_ff == LRE_S_EXEC);
  chk_jump_forward: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    exec_now && rung_true && act >= `LRE_A_JUMP_LO &&
    act <= `LRE_A_JUMP_HI && jump_tgt > rung_ff
    |=> rung_ff == $past(jump_tgt) && state_ff == LRE_S_READ)
    else $error("forward jump not taken to its target");
  // a refused jump from the last rung ends the scan at rung zero
  chk_jump_error: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    exec_now && rung_true && act >= `LRE_A_JUMP_LO &&
    act <= `LRE_A_JUMP_HI && jump_tgt <= rung_ff
    |=> status_ff[`LRE_ST_JUMP_ERR] &&
        (state_ff == LRE_S_IDLE || rung_ff == $past(rung_ff) + 5'h1))
    else $error("backward jump not flagged");
  chk_plc_reset: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    exec_now && rung_true && act == `LRE_A_PLC_RESET
    |=> vars_ff == 10'h0 && o_timer_expire ##1 !o_timer_expire)
    else $error("logic reset did not clear state");
  chk_heater_follow: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    exec_now && act == `LRE_A_HEATER |=> o_heater_en == $past(rung_true))
    else $error("heater does not follow condition");
  chk_zero_speed: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    o_zero_speed == (o_preset_idx == `LRE_PRESET_ZERO))
    else $error("zero speed select mismatch");
  chk_scan_start: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    state_ff == LRE_S_IDLE && ctrl_run_ff
    |=> pacc_ff == 4'h0 && tacc_ff == 2'h0 && rung_ff == 5'h0
        ##1 state_ff == LRE_S_EXEC)
    else $error("scan did not start at rung zero");
  chk_rung_order: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    exec_now && rung_ff != `LRE_LAST_RUNG &&
    !(act >= `LRE_A_JUMP_LO && act <= `LRE_A_JUMP_HI && rung_true)
    |=> rung_ff == $past(rung_ff) + 5'h1)
    else $error("rung order broken");
  chk_var_set: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    exec_now && act == `LRE_A_VAR_LO |=> vars_ff[0] == $past(rung_true))
    else $error("variable A not updated");
endmodule : lre_evaluator

// ===== hw/lre_rung_mem.sv
// rung word store, one write port and one registered read port
`timescale 1ns/1ns
`include "lre_defines.svh"
module lre_rung_mem (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // write side
  input  wire logic        i_we,
  input  wire logic [4:0]  i_waddr,
  input  wire logic [31:0] i_wdata,
  // read side
  input  wire logic [4:0]  i_raddr,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem_ff [0:29];
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = (i_raddr <= `LRE_LAST_RUNG) ? mem_ff[i_raddr] : 32'h0;
  end

  // reset clears every rung so an unprogrammed rung is a harmless no-op
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < 30; k++) begin
        mem_ff[k] <= 32'h0;
      end
      o_rdata <= 32'h0;
    end else begin
      if (i_we && (i_waddr <= `LRE_LAST_RUNG)) begin
        mem_ff[i_waddr] <= i_wdata;
      end
      o_rdata <= nxt_rdata;
    end
  end
endmodule : lre_rung_mem

// ===== include/lre_defines.svh
// constants for the ladder rung action evaluator
`ifndef LRE_DEFINES_SVH
`define LRE_DEFINES_SVH
// register word addresses on the plain port
`define LRE_ADDR_RUNG_LAST 8'h1D
`define LRE_ADDR_CTRL      8'h20
`define LRE_ADDR_STATUS    8'h21
`define LRE_ADDR_MASK      8'h22
`define LRE_ADDR_STATE     8'h23
// status / mask bit positions
`define LRE_ST_JUMP_ERR    0
`define LRE_ST_SCAN_DONE   1
`define LRE_ST_PLC_RESET   2
`define LRE_ST_W           3
// control bit positions and reset value
`define LRE_CTRL_RUN       0
`define LRE_CTRL_RST_VAL   1'h0
// rung word fields
`define LRE_F_COND_A       31:24
`define LRE_F_LOGIC        23:16
`define LRE_F_COND_B       15:8
`define LRE_F_ACTION       7:0
// rung count
`define LRE_NUM_RUNGS      5'h1E
`define LRE_LAST_RUNG      5'h1D
// logic operators
`define LRE_OP_OR          8'h00
`define LRE_OP_AND         8'h01
`define LRE_OP_XOR         8'h02
`define LRE_OP_NOR         8'h03
// condition codes
`define LRE_C_FALSE        8'h00
`define LRE_C_TRUE         8'h01
`define LRE_C_DIN_LO       8'h32
`define LRE_C_DIN_HI       8'h41
`define LRE_C_CMP_LO       8'h4C
`define LRE_C_CMP_HI       8'h4F
`define LRE_C_TMR_LO       8'h56
`define LRE_C_TMR_HI       8'h59
`define LRE_C_VAR_LO       8'h64
`define LRE_C_VAR_HI       8'h6D
// action codes
`define LRE_A_PRESET_LO    8'h19
`define LRE_A_PRESET_HI    8'h1C
`define LRE_A_TABLE_LO     8'h23
`define LRE_A_TABLE_HI     8'h24
`define LRE_A_VAR_LO       8'h28
`define LRE_A_VAR_HI       8'h31
`define LRE_A_PLC_RESET    8'h45
`define LRE_A_JUMP_LO      8'h46
`define LRE_A_JUMP_HI      8'h63
`define LRE_A_HEATER       8'h96
// preset index that selects zero speed
`define LRE_PRESET_ZERO    4'hF
`endif

// ===== include/lre_pkg.sv
// types shared by the ladder rung action evaluator
package lre_pkg;
  typedef enum logic [1:0] {
    LRE_S_IDLE,
    LRE_S_READ,
    LRE_S_EXEC
  } lre_state_t;
endpackage : lre_pkg

// ===== tb/lre_drive_model.sv
// drive-side model: input switches, timers and preset speed selection
`timescale 1ns/1ns
module lre_drive_model (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // switch levels and timer hold from the bench
  input  wire logic [15:0] i_sw,
  input  wire logic        i_tmr_run,
  // evaluator outputs
  input  wire logic [3:0]  i_preset_idx,
  input  wire logic        i_timer_expire,
  // levels toward the evaluator
  output logic      [15:0] o_din,
  output logic      [3:0]  o_comp,
  output logic      [3:0]  o_timer_done,
  // preset in use, zero means zero speed
  output logic      [4:0]  o_sel_preset
);
  assign o_din  = i_sw;
  // comparators keep their own state, the evaluator never touches them
  assign o_comp = 4'hA;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_timer_done <= 4'h0;
    end else if (i_timer_expire) begin
      o_timer_done <= 4'hF;
    end else if (i_tmr_run) begin
      o_timer_done <= 4'h0;
    end
  end
  // an all-ones index has no stored preset behind it
  assign o_sel_preset = (i_preset_idx == 4'hF) ? 5'h00
                                               : {1'b0, i_preset_idx} + 5'h01;
endmodule : lre_drive_model

// ===== tb/lre_evaluator_tb.sv
// self-checking bench for the ladder rung evaluator
`timescale 1ns/1ns
`include "lre_defines.svh"
module lre_evaluator_tb;
  // ********************
  // signals
  // ********************
  logic        i_sys_clk, i_rst_b, i_wr, i_rd, tmr_run;
  logic        o_zero_speed, o_heater_en, o_timer_expire, o_irq;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rd_val;
  logic [15:0] sw, din;
  logic [3:0]  comp, tdone, o_preset_idx, pat;
  logic [1:0]  o_table_idx;
  logic [4:0]  sel_preset;
  logic [3:0]  pats [4] = '{4'h0, 4'h5, 4'hE, 4'hF};
  logic [7:0]  ops [4] = '{8'h00, 8'h01, 8'h03, 8'h02};
  int          n_mismatch, n_checks, k, j;

  lre_evaluator DUT (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_din(din), .i_comp(comp), .i_timer_done(tdone),
    .o_preset_idx(o_preset_idx), .o_zero_speed(o_zero_speed),
    .o_table_idx(o_table_idx), .o_heater_en(o_heater_en),
    .o_timer_expire(o_timer_expire), .o_irq(o_irq));
  lre_drive_model drive (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_sw(sw),
    .i_tmr_run(tmr_run), .i_preset_idx(o_preset_idx),
    .i_timer_expire(o_timer_expire), .o_din(din), .o_comp(comp),
    .o_timer_done(tdone), .o_sel_preset(sel_preset));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // ********************
  // access tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1 rd_val = o_rdata;
  endtask : rd
  function automatic logic [31:0] rung(input logic [7:0] ca, op, cb, act);
    return {ca, op, cb, act};
  endfunction : rung
  task automatic clr();
    for (int r = 0; r < 30; r++) wr(8'(r), 32'h0);
  endtask : clr
  // two full scans, the second started before the run bit is dropped again; dropping it lets the program change
  task automatic scan();
    int i;
    wr(`LRE_ADDR_STATUS, 32'h7);
    wr(`LRE_ADDR_CTRL, 32'h1);
    for (i = 0; i < 200; i++) begin
      rd(`LRE_ADDR_STATUS);
      if (rd_val[`LRE_ST_SCAN_DONE] === 1'b1) break;
    end
    if (i == 200) begin
      n_mismatch++;
      report_and_stop();
    end
    wr(`LRE_ADDR_CTRL, 32'h0);
    repeat (70) @(posedge i_sys_clk);
  endtask : scan
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // ********************
  // tests
  // ********************
  initial begin
    i_rst_b = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00;
    i_wdata = 32'h0; sw = 16'h0; tmr_run = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd(`LRE_ADDR_CTRL); chk(rd_val, 32'h0);
    rd(8'h30); chk(rd_val, 32'h0);
    rd(8'h05); chk(rd_val, 32'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      wr(8'(k), rung(8'h32 + 8'(k), 8'h00, 8'h00, 8'h19 + 8'(k)));
    end
    wr(8'h04, rung(8'h36, 0, 0, 8'h23));
    wr(8'h05, rung(8'h37, 0, 0, 8'h24));
    for (k = 0; k < 4; k++) begin
      pat = pats[k];
      sw <= {10'h000, ~pat[1:0], pat};
      scan();
      chk(32'(o_preset_idx), 32'(pat));
      chk(32'(o_zero_speed), 32'(pat == 4'hF));
      chk(32'(sel_preset), pat == 4'hF ? 32'h0 : 32'(pat) + 1);
      chk(32'(o_table_idx), {30'h0, ~pat[1:0]});
    end
    clr();
    scan();
    chk(32'(o_preset_idx), 32'h0);
    $display("test index done");
    for (j = 0; j < 4; j++) for (k = 0; k < 4; k++) begin
      wr(8'h00, rung(8'h32, ops[j], 8'h33, 8'h19));
      sw <= 16'(k);
      scan();
      chk(32'(o_preset_idx[0]), j == 0 ? 32'(k != 0) : j == 1 ? 32'(k == 3)
          : j == 2 ? 32'(k == 0) : 32'(k == 1 || k == 2));
    end
    $display("test logic done");
    wr(8'h00, rung(8'h01, 0, 0, 8'h28));
    wr(8'h01, rung(8'h64, 1, 8'h01, 8'h1A));
    wr(8'h02, rung(8'h32, 0, 0, 8'h45));
    wr(8'h03, rung(8'h64, 0, 0, 8'h1B));
    sw <= 16'h0;
    scan();
    chk(32'(o_preset_idx), 32'h6);
    rd(`LRE_ADDR_STATE); chk(32'(rd_val[17:8]), 32'h1);
    chk(32'(tdone), 32'h0);
    @(posedge i_sys_clk);
    tmr_run <= 1'b0;
    sw <= 16'h1;
    scan();
    chk(32'(o_preset_idx), 32'h2);
    rd(`LRE_ADDR_STATE); chk(32'(rd_val[17:8]), 32'h0);
    rd(`LRE_ADDR_STATUS); chk(32'(rd_val[2]), 32'h1);
    chk(32'(tdone), 32'hF);
    chk(32'(comp), 32'hA);
    // comparator and expired timer still read true after the logic reset
    wr(8'h03, rung(8'h4D, 8'h01, 8'h56, 8'h1B));
    scan();
    chk(32'(o_preset_idx), 32'h6);
    $display("test logic reset done");
    wr(8'h00, rung(8'h01, 0, 0, 8'h48));
    wr(8'h01, rung(8'h01, 0, 0, 8'h96));
    wr(8'h02, rung(8'h32, 0, 0, 8'h19));
    wr(8'h03, rung(8'h01, 0, 0, 8'h47));
    wr(8'h04, rung(8'h33, 0, 0, 8'h96));
    wr(`LRE_ADDR_MASK, 32'h1);
    scan();
    chk(32'(o_heater_en), 32'h0);
    chk(32'(o_preset_idx), 32'h1);
    rd(`LRE_ADDR_STATUS); chk(32'(rd_val[0]), 32'h1);
    chk(32'(o_irq), 32'h1);
    wr(`LRE_ADDR_STATUS, 32'h1);
    repeat (2) @(posedge i_sys_clk);
    #1 chk(32'(o_irq), 32'h0);
    wr(`LRE_ADDR_MASK, 32'h0);
    sw <= 16'h3;
    scan();
    chk(32'(o_heater_en), 32'h1);
    rd(`LRE_ADDR_STATUS); chk(32'(rd_val[0]), 32'h1);
    chk(32'(o_irq), 32'h0);
    @(posedge i_sys_clk);
    sw <= 16'h1;
    scan();
    chk(32'(o_heater_en), 32'h0);
    $display("test jump heater done");
    clr();
    for (k = 1; k < 30; k++) begin
      wr(8'h00, rung(8'h01, 0, 0, 8'h46 + 8'(k)));
      wr(8'(k), rung(8'h01, 0, 0, 8'h19));
      if (k > 1) wr(8'(k - 1), rung(8'h01, 0, 0, 8'h1A));
      if (k > 2) wr(8'(k - 2), 32'h0);
      scan();
      chk(32'(o_preset_idx), 32'h1);
      rd(`LRE_ADDR_STATUS); chk(32'(rd_val[0]), 32'h0);
    end
    $display("test jump targets done");
    report_and_stop();
  end
endmodule : lre_evaluator_tb
